// file: logic/hcr_pkg.sv
/*
  Constants, types and decode helpers for the hub configuration register
  block. Assumes a 40 MHz system clock and a 32-bit AHB-Lite register bus.
*/
// Overview of operation
// RQ1 - Count stop-grants; ack on hub link after 1 (code 000) or 2 (001).
// RQ2 - Software programs stop-grant count once, before stop-clock generation; never changes it.
// RQ3 - Every enabled thread's stop-grant counts separately toward the programmed total.
// RQ4 - Memory frequency select resets to 00.
// RQ5 - Memory frequency from bus code and select: 333, 333 (320) or 400 MHz.
// RQ6 - Memory I/O clock always runs at twice the memory clock.
// RQ7 - New register timings take effect only after the clock synchronisation sequence.
// RQ8 - Software sets mono display present only with graphics VGA enable set.
// RQ9 - VGA enable clear: I/O 3BCh-3BFh goes to the hub link.
// RQ10 - MDA is memory 0B0000h-0B7FFFh, I/O 3B4/5/8/9/A/Fh, A[15:10] ignored.
// RQ11 - Any I/O reference touching an MDA location goes to the hub link; with VGA enabled and mono display present clear, only 3BFh does.
// RQ12 - VGA enabled: VGA to graphics bridge, 3BFh-only references to hub link.
// RQ13 - Both VGA and MDA clear send all to hub link; VGA clear, MDA set illegal.
// RQ14 - Reserved bits 12 and 9:6 ignore writes and read as zero.
package hcr_pkg;
  // Register map, index kept as printed, byte address is four times it
  localparam logic [11:0] CFG_INDEX = 12'h0c6;
  localparam logic [11:0] SYNC_INDEX = 12'h0c8;
  localparam logic [31:0] CFG_ADDR = {18'h00000, CFG_INDEX, 2'b00};
  localparam logic [31:0] SYNC_ADDR = {18'h00000, SYNC_INDEX, 2'b00};
  localparam int AHB_DW = 32;
  // Configuration register layout
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_WMASK = 16'hec20;
  localparam int SGC_LSB = 13;
  localparam int SEL_LSB = 10;
  localparam int MONO_BIT = 5;
  localparam int SYNC_START_BIT = 0;
  localparam logic [2:0] SGC_ONE = 3'h0;
  localparam logic [2:0] SGC_TWO = 3'h1;
  localparam logic [1:0] SEL_RESET = 2'h0;
  // Frequency table
  localparam logic [1:0] BUS_CODE_LOW = 2'h1;
  localparam logic [1:0] BUS_CODE_HIGH = 2'h2;
  localparam logic [1:0] SEL_LOW = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  localparam logic [9:0] MHZ_NONE = 10'h000;
  localparam logic [9:0] MHZ_333 = 10'h14d;
  localparam logic [9:0] MHZ_320 = 10'h140;
  localparam logic [9:0] MHZ_400 = 10'h190;
  // AHB encodings
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  // Synchronisation sequence length
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYNC_TIME_NS = 500;
  localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SYNC_CNT_LOAD = 8'(SYNC_CYCLES - 1);
  // Legacy display decode
  localparam logic [31:0] MDA_MEM_LO = 32'h000b0000;
  localparam logic [31:0] MDA_MEM_END = 32'h000b7fff;
  localparam logic [31:0] VGA_MEM_LO = 32'h000a0000;
  localparam logic [31:0] VGA_MEM_END = 32'h000bffff;
  localparam logic [9:0] MDA_ONLY_IO = 10'h3bf;
  localparam logic [9:0] LPT_IO_LO = 10'h3bc;

  typedef enum logic [0:0] {SYNC_IDLE, SYNC_BUSY} hcr_sync_e;

  // MDA I/O locations, only A[9:0] take part
  function automatic logic hcr_io_is_mda(input logic [9:0] a);
    return (a == 10'h3b4) || (a == 10'h3b5) || (a == 10'h3b8) || (a == 10'h3b9) || (a == 10'h3ba) || (a == 10'h3bf);
  endfunction : hcr_io_is_mda

  // VGA I/O ranges 3B0h-3BBh and 3C0h-3DFh
  function automatic logic hcr_io_is_vga(input logic [9:0] a);
    return ((a >= 10'h3b0) && (a <= 10'h3bb)) || ((a >= 10'h3c0) && (a <= 10'h3df));
  endfunction : hcr_io_is_vga
endpackage : hcr_pkg

// file: logic/hcr_stop_grant.sv
/*
  Stop-grant counter: turns processor stop-grant transactions into hub link
  acknowledges. Assumes one transaction pulse per cycle at most.
*/
`timescale 1ns/1ps
module hcr_stop_grant (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Processor side
  input wire logic stop_grant_i,
  input wire logic [2:0] stop_grant_count_i,
  // Hub link side
  output logic ack_o
);
  import hcr_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic ack;
  } hcr_sg_s;

  hcr_sg_s s;
  hcr_sg_s n;
  logic [1:0] target;

  // Reserved codes behave like one per acknowledge, never stalling the hub
  assign target = (stop_grant_count_i == SGC_TWO) ? 2'h2 : 2'h1; // RQ1

  // Every thread pulse counts, no source filtering
  always_comb begin
    n = s;
    n.ack = 1'b0;
    if (stop_grant_i) begin
      if (s.cnt + 2'h1 >= target) begin
        n.cnt = 2'h0; // RQ3
        n.ack = 1'b1; // RQ1
      end else begin
        n.cnt = s.cnt + 2'h1; // RQ3
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign ack_o = s.ack;

  AST_ACK_AFTER_ONE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ1
    stop_grant_i && stop_grant_count_i == SGC_ONE |=> ack_o) else $error("ack missing after single stop-grant");
  AST_ACK_NEEDS_TWO: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ3
    ack_o && $past(stop_grant_count_i) == SGC_TWO |-> $past(s.cnt) == 2'h1) else $error("ack before second stop-grant");
  AST_ACK_HAS_CAUSE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ3
    ack_o |-> $past(stop_grant_i)) else $error("ack without stop-grant");
  COV_TWO_TO_ONE: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    stop_grant_count_i == SGC_TWO && stop_grant_i ##1 stop_grant_i ##1 ack_o);
endmodule : hcr_stop_grant

// file: logic/hcr_mda_route.sv
/*
  Legacy display routing: decides where processor I/O and memory references
  to MDA and VGA ranges go. Assumes I/O addresses dword aligned with lane enables.
*/
`timescale 1ns/1ps
module hcr_mda_route (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Processor references
  input wire logic io_valid_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [3:0] io_byte_en_i,
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_addr_i,
  // Routing controls
  input wire logic vga_enable_i,
  input wire logic mono_display_present_i,
  // Decision
  output logic valid_o,
  output logic hub_link_o,
  output logic graphics_o,
  output logic other_o
);
  import hcr_pkg::*;

  typedef struct packed {
    logic valid;
    logic hub;
    logic gfx;
    logic other;
  } hcr_rt_s;

  hcr_rt_s s;
  hcr_rt_s n;
  logic mda_hit;
  logic vga_hit;
  logic only_hit;
  logic lpt_hit;
  logic [9:0] lane_addr;

  // Lane decode on A[9:0] so ISA aliases match too
  always_comb begin
    mda_hit = 1'b0;
    vga_hit = 1'b0;
    only_hit = 1'b0;
    lpt_hit = 1'b0;
    lane_addr = '0;
    for (int i = 0; i < 4; i++) begin
      lane_addr = {io_addr_i[9:2], 2'(i)};
      if (io_valid_i && io_byte_en_i[i]) begin
        mda_hit = mda_hit | hcr_io_is_mda(lane_addr); // RQ10
        vga_hit = vga_hit | hcr_io_is_vga(lane_addr);
        only_hit = only_hit | (lane_addr == MDA_ONLY_IO);
        lpt_hit = lpt_hit | (lane_addr >= LPT_IO_LO && lane_addr <= MDA_ONLY_IO);
      end
    end
    if (mem_valid_i) begin
      mda_hit = mem_addr_i >= MDA_MEM_LO && mem_addr_i <= MDA_MEM_END; // RQ10
      vga_hit = mem_addr_i >= VGA_MEM_LO && mem_addr_i <= VGA_MEM_END;
    end
  end

  // Hub link wins whenever an MDA location is touched, except with VGA enabled and no mono display present
  always_comb begin
    n = '0;
    n.valid = io_valid_i || mem_valid_i;
    if (!vga_enable_i) begin
      n.hub = lpt_hit || mda_hit || vga_hit; // RQ9 RQ13
    end else if (mono_display_present_i) begin
      n.hub = mda_hit; // RQ11
      n.gfx = vga_hit && !mda_hit;
    end else begin
      n.hub = only_hit; // RQ12
      n.gfx = vga_hit && !only_hit; // RQ12
    end
    n.other = n.valid && !n.hub && !n.gfx;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign valid_o = s.valid;
  assign hub_link_o = s.hub;
  assign graphics_o = s.gfx;
  assign other_o = s.other;

  AST_MDA_TO_HUB: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ11
    vga_enable_i && mono_display_present_i && mda_hit |=> hub_link_o && !graphics_o) else $error("MDA not on hub");
  AST_VGA_OFF_HUB: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ9
    !vga_enable_i && (lpt_hit || vga_hit) |=> hub_link_o) else $error("VGA off reference not on hub");
  AST_VGA_TO_GFX: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ12
    vga_enable_i && !mono_display_present_i && vga_hit && !only_hit |=> graphics_o) else $error("VGA not on graphics");
  COV_GFX: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) graphics_o);
endmodule : hcr_mda_route

// file: logic/hcr_top.sv
/*
  Hub configuration register over AHB-Lite, with the clock synchronisation
  gate, memory frequency selection, stop-grant counter and MDA routing.
  Assumes a single AHB-Lite master and synchronous side inputs.
*/
`timescale 1ns/1ps
module hcr_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [hcr_pkg::AHB_DW-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [hcr_pkg::AHB_DW-1:0] hwdata_i,
  input wire logic hready_i,
  output logic [hcr_pkg::AHB_DW-1:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Processor bus
  input wire logic [1:0] processor_bus_frequency_code_i,
  input wire logic proc_stop_grant_i,
  input wire logic proc_io_valid_i,
  input wire logic [15:0] proc_io_addr_i,
  input wire logic [3:0] proc_io_byte_en_i,
  input wire logic proc_mem_valid_i,
  input wire logic [31:0] proc_mem_addr_i,
  // Graphics bridge
  input wire logic graphics_bridge_vga_enable_i,
  // Hub link and routing
  output logic hub_link_stop_grant_ack_o,
  output logic route_valid_o,
  output logic route_hub_link_o,
  output logic route_graphics_o,
  output logic route_other_o,
  // Memory clocking
  output logic [9:0] memory_clock_mhz_o,
  output logic [10:0] memory_io_clock_mhz_o,
  output logic memory_frequency_reserved_o,
  output logic mda_vga_illegal_o
);
  import hcr_pkg::*;

  typedef struct packed {
    logic [15:0] cfg;
    logic [1:0] applied_sel;
    logic sync_pending;
    hcr_sync_e sync_state;
    logic [7:0] sync_cnt;
    logic dp_wr_cfg;
    logic dp_wr_sync;
    logic [31:0] rdata;
    logic hreadyout;
    logic [9:0] mem_mhz;
    logic [10:0] io_mhz;
    logic freq_rsvd;
    logic illegal;
  } hcr_top_s;

  localparam hcr_top_s TOP_RESET = '{
    cfg: CFG_RESET,
    applied_sel: SEL_RESET,
    sync_pending: 1'b0,
    sync_state: SYNC_IDLE,
    sync_cnt: 8'h00,
    dp_wr_cfg: 1'b0,
    dp_wr_sync: 1'b0,
    rdata: 32'h00000000,
    hreadyout: 1'b1,
    mem_mhz: MHZ_NONE,
    io_mhz: 11'h000,
    freq_rsvd: 1'b1,
    illegal: 1'b0
  };

  hcr_top_s s;
  hcr_top_s n;
  logic ap_valid;
  logic ap_write;
  logic sync_done;

  // Frequency table; anything unlisted is reserved and reads as zero MHz
  function automatic logic [9:0] mem_mhz_of(input logic [1:0] bus, input logic [1:0] sel);
    logic [9:0] mhz;
    mhz = MHZ_NONE;
    if (bus == BUS_CODE_LOW && sel == SEL_LOW) begin
      mhz = MHZ_333;
    end else if (bus == BUS_CODE_HIGH && sel == SEL_LOW) begin
      mhz = MHZ_320;
    end else if (bus == BUS_CODE_HIGH && sel == SEL_HIGH) begin
      mhz = MHZ_400;
    end
    return mhz;
  endfunction : mem_mhz_of

  // Address phase qualification; byte writes cannot hold a 16-bit field
  assign ap_valid = hsel_i && hready_i && htrans_i[1];
  assign ap_write = ap_valid && hwrite_i && (hsize_i >= HSIZE_HALF);
  assign sync_done = (s.sync_state == SYNC_BUSY) && (s.sync_cnt == 8'h00);

  // Next state of the whole block
  always_comb begin
    n = s;
    n.hreadyout = 1'b1;
    // Data phase write; reserved bits never take a written one
    if (s.dp_wr_cfg) begin
      n.cfg = (s.cfg & ~CFG_WMASK) | (hwdata_i[15:0] & CFG_WMASK); // RQ14
      n.sync_pending = 1'b1; // RQ7
    end
    // Synchronisation gate: timings move only at its end
    case (s.sync_state)
      SYNC_IDLE: begin
        if (s.dp_wr_sync && hwdata_i[SYNC_START_BIT]) begin
          n.sync_state = SYNC_BUSY;
          n.sync_cnt = SYNC_CNT_LOAD;
        end
      end
      SYNC_BUSY: begin
        if (sync_done) begin
          n.sync_state = SYNC_IDLE;
          n.applied_sel = s.cfg[SEL_LSB +: 2]; // RQ7
          // A write landing in the last cycle keeps pending set
          n.sync_pending = s.dp_wr_cfg;
        end else begin
          n.sync_cnt = s.sync_cnt - 8'h01;
        end
      end
      default: begin
        n.sync_state = SYNC_IDLE;
      end
    endcase
    // Address phase capture
    n.dp_wr_cfg = ap_write && (haddr_i == CFG_ADDR);
    n.dp_wr_sync = ap_write && (haddr_i == SYNC_ADDR);
    // Read data from the updated copy so a trailing write is visible
    n.rdata = 32'h00000000;
    if (ap_valid && !hwrite_i) begin
      if (haddr_i == CFG_ADDR) begin
        n.rdata = {16'h0000, n.cfg}; // RQ14
      end else if (haddr_i == SYNC_ADDR) begin
        n.rdata = {26'h0000000, s.illegal, s.freq_rsvd, n.applied_sel, n.sync_pending, n.sync_state == SYNC_BUSY};
      end
    end
    // Memory clocking follows the applied select only
    n.mem_mhz = mem_mhz_of(processor_bus_frequency_code_i, s.applied_sel); // RQ5
    n.io_mhz = {n.mem_mhz, 1'b0}; // RQ6
    n.freq_rsvd = (n.mem_mhz == MHZ_NONE); // RQ5
    // Flag the combination that software must not program
    n.illegal = !graphics_bridge_vga_enable_i && s.cfg[MONO_BIT]; // RQ8 RQ13
  end

  // Single state register; memory select resets to zero with the rest
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= TOP_RESET; // RQ4
    end else begin
      s <= n;
    end
  end

  // Bus answers come straight from state; OKAY always, no wait states
  assign hrdata_o = s.rdata;
  assign hreadyout_o = s.hreadyout;
  assign hresp_o = 1'b0;
  assign memory_clock_mhz_o = s.mem_mhz;
  assign memory_io_clock_mhz_o = s.io_mhz;
  assign memory_frequency_reserved_o = s.freq_rsvd;
  assign mda_vga_illegal_o = s.illegal;

  // Stop-grant counting reads the live field; it is set once before use
  hcr_stop_grant u_stop_grant (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .stop_grant_i(proc_stop_grant_i),
    .stop_grant_count_i(s.cfg[SGC_LSB +: 3]), // RQ2
    .ack_o(hub_link_stop_grant_ack_o)
  );

  // Routing is not a timing, so the present bit takes effect at once
  hcr_mda_route u_mda_route (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .io_valid_i(proc_io_valid_i),
    .io_addr_i(proc_io_addr_i),
    .io_byte_en_i(proc_io_byte_en_i),
    .mem_valid_i(proc_mem_valid_i),
    .mem_addr_i(proc_mem_addr_i),
    .vga_enable_i(graphics_bridge_vga_enable_i),
    .mono_display_present_i(s.cfg[MONO_BIT]),
    .valid_o(route_valid_o),
    .hub_link_o(route_hub_link_o),
    .graphics_o(route_graphics_o),
    .other_o(route_other_o)
  );

  // Reserved bits stay zero on every read of the register
  AST_RSVD_READ_ZERO: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ14
    ap_valid && !hwrite_i && haddr_i == CFG_ADDR |=> (hrdata_o & ~{16'h0000, CFG_WMASK}) == 32'h00000000)
    else $error("reserved bits read nonzero");

  // Select moves only at the end of a synchronisation
  AST_SELECT_HELD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ7
    s.applied_sel != $past(s.applied_sel) |-> $past(sync_done)) else $error("select applied without sync");

  // End of sync takes the register value
  AST_SELECT_APPLIED: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ7
    sync_done |=> s.applied_sel == $past(s.cfg[SEL_LSB +: 2])) else $error("sync did not apply select");

  // Sync never lasts beyond its load value
  AST_SYNC_BOUND: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ7
    s.sync_state == SYNC_BUSY |-> s.sync_cnt <= SYNC_CNT_LOAD) else $error("sync counter out of range");

  // I/O clock is twice the memory clock in every state
  AST_IO_TWICE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ6
    memory_io_clock_mhz_o == {memory_clock_mhz_o, 1'b0}) else $error("I/O clock not double");

  // High bus code with high select gives 400 MHz
  AST_FREQ_400: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ5
    processor_bus_frequency_code_i == BUS_CODE_HIGH && s.applied_sel == SEL_HIGH |=> memory_clock_mhz_o == MHZ_400)
    else $error("400 MHz not selected");

  // Low bus code with low select gives 333 MHz
  AST_FREQ_333: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ5
    processor_bus_frequency_code_i == BUS_CODE_LOW && s.applied_sel == SEL_LOW |=> memory_clock_mhz_o == MHZ_333)
    else $error("333 MHz not selected");

  // First cycle out of reset shows select 00
  AST_SELECT_RESET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ4
    $rose(reset_n_i) |-> s.cfg[SEL_LSB +: 2] == SEL_RESET && s.applied_sel == SEL_RESET)
    else $error("select not zero after reset");

  // Illegal combination is reported within one cycle
  AST_ILLEGAL_FLAG: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RQ13
    !graphics_bridge_vga_enable_i && s.cfg[MONO_BIT] |=> mda_vga_illegal_o) else $error("illegal combo not flagged");

  // Main scenarios
  COV_SYNC_DONE: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) sync_done);
  COV_CFG_WRITE: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) s.dp_wr_cfg);
  COV_HUB_ROUTE: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) route_hub_link_o);
endmodule : hcr_top

// file: sim/hcr_proc_model.sv
/*
  Processor bus model: issues stop-grant transactions, one pulse per
  enabled thread, back to back or with a one-cycle gap between pulses.
  Assumes the bench starts a burst only while the model is idle.
*/
`timescale 1ns/1ps
module hcr_proc_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Commands from the bench
  input wire logic start_i,
  input wire logic [3:0] pulses_i,
  input wire logic slow_i,
  // Processor bus
  output logic stop_grant_o,
  output logic idle_o
);
  logic [3:0] left;
  logic gap;

  // Each thread sends its own pulse; slow mode leaves a gap after each
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      left <= 4'h0;
      gap <= 1'b0;
      stop_grant_o <= 1'b0;
    end else if (start_i) begin
      left <= pulses_i;
      gap <= 1'b0;
      stop_grant_o <= 1'b0;
    end else if (left != 4'h0 && !gap) begin
      stop_grant_o <= 1'b1;
      left <= left - 4'h1;
      gap <= slow_i;
    end else begin
      stop_grant_o <= 1'b0;
      gap <= 1'b0;
    end
  end

  // Idle once the burst is out and the last pulse has dropped
  assign idle_o = (left == 4'h0) && !stop_grant_o;
endmodule : hcr_proc_model

// file: sim/tb.sv
/*
  Self-checking bench for the hub configuration register block.
  Assumes a single AHB-Lite master with hready taken from the slave.
*/
`timescale 1ns/1ps
module tb;
  import hcr_pkg::*;
  typedef struct packed {logic vga; logic mda; logic mem; logic [31:0] addr; logic [3:0] be; logic [2:0] exp;} hcr_rc_s;
  // Routing cases, expected {hub, graphics, other}
  localparam hcr_rc_s RC [14] = '{
    '{1'b0, 1'b0, 1'b0, 32'h3bc, 4'h8, 3'b100}, '{1'b0, 1'b0, 1'b0, 32'h3b4, 4'h1, 3'b100},
    '{1'b0, 1'b0, 1'b1, 32'ha0000, 4'h0, 3'b100}, '{1'b1, 1'b0, 1'b0, 32'h3bc, 4'h8, 3'b100},
    '{1'b1, 1'b0, 1'b0, 32'h3b4, 4'h1, 3'b010}, '{1'b1, 1'b0, 1'b0, 32'h3c0, 4'h1, 3'b010},
    '{1'b1, 1'b1, 1'b0, 32'h7b8, 4'h1, 3'b100}, '{1'b1, 1'b1, 1'b0, 32'h3b4, 4'hc, 3'b010},
    '{1'b1, 1'b1, 1'b0, 32'h3b8, 4'hf, 3'b100}, '{1'b1, 1'b1, 1'b1, 32'hb7fff, 4'h0, 3'b100},
    '{1'b1, 1'b1, 1'b1, 32'hb8000, 4'h0, 3'b010}, '{1'b1, 1'b0, 1'b1, 32'hb0000, 4'h0, 3'b010},
    '{1'b1, 1'b1, 1'b0, 32'h100, 4'h1, 3'b001}, '{1'b0, 1'b1, 1'b0, 32'h3b4, 4'h1, 3'b100}};
  localparam logic [1:0] FB [4] = '{2'h1, 2'h2, 2'h2, 2'h1};
  localparam logic [1:0] FS [4] = '{2'h1, 2'h1, 2'h2, 2'h2};
  // Clock, reset and bench drives
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, io_valid = 1'b0, mem_valid = 1'b0, vga = 1'b0, start = 1'b0, slow = 1'b0;
  logic [1:0] htrans = 2'h0, bus_code = 2'h0, asel = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, mem_addr = 32'h0, rdat;
  logic [15:0] io_addr = 16'h0;
  logic [3:0] io_be = 4'h0, pulses = 4'h0;
  // Design outputs
  logic [31:0] hrdata;
  logic hready, hresp, sg, ack, rvalid, rhub, rgfx, roth, resv, illegal, idle;
  logic [9:0] mhz;
  logic [10:0] iomhz;
  int err_total = 0;
  int comparisons = 0;
  int ack_cnt = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;

  hcr_top dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .processor_bus_frequency_code_i(bus_code), .proc_stop_grant_i(sg),
    .proc_io_valid_i(io_valid), .proc_io_addr_i(io_addr), .proc_io_byte_en_i(io_be), .proc_mem_valid_i(mem_valid),
    .proc_mem_addr_i(mem_addr), .graphics_bridge_vga_enable_i(vga), .hub_link_stop_grant_ack_o(ack),
    .route_valid_o(rvalid), .route_hub_link_o(rhub), .route_graphics_o(rgfx), .route_other_o(roth),
    .memory_clock_mhz_o(mhz), .memory_io_clock_mhz_o(iomhz), .memory_frequency_reserved_o(resv),
    .mda_vga_illegal_o(illegal));

  hcr_proc_model proc (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .start_i(start), .pulses_i(pulses),
    .slow_i(slow), .stop_grant_o(sg), .idle_o(idle));

  // Count acknowledges; a stretched pulse would count twice
  always @(posedge sys_clk_i) if (ack === 1'b1) ack_cnt++;

  task give_verdict;
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One single transfer; entered just after a rising edge
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    @(posedge sys_clk_i);
    while (hready !== 1'b1) @(posedge sys_clk_i);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge sys_clk_i);
    while (hready !== 1'b1) @(posedge sys_clk_i);
    rdat = hrdata;
  endtask : ahb

  function automatic logic [9:0] mhz_of(input logic [1:0] b, input logic [1:0] s);
    if (b == 2'h1 && s == 2'h1) return 10'd333;
    if (b == 2'h2 && s == 2'h1) return 10'd320;
    if (b == 2'h2 && s == 2'h2) return 10'd400;
    return 10'd0;
  endfunction : mhz_of

  // Start the synchronisation and poll busy under a bound
  task sync_wait;
    int n;
    n = 0;
    ahb(1'b1, SYNC_ADDR, 32'h1);
    rdat = 32'h1;
    while (rdat[0] === 1'b1 && n < 40) begin
      ahb(1'b0, SYNC_ADDR, 32'h0);
      n++;
    end
    check(rdat[1:0], 2'h0);
  endtask : sync_wait

  // New select must wait for the synchronisation; bus code acts live
  task freq_case(input logic [1:0] b, input logic [1:0] s);
    logic [9:0] m;
    bus_code <= b;
    ahb(1'b1, CFG_ADDR, {20'h0, s, 10'h0});
    ahb(1'b0, SYNC_ADDR, 32'h0);
    check(rdat[1], 1'b1);
    check(mhz, mhz_of(b, asel));
    sync_wait;
    asel = s;
    m = mhz_of(b, s);
    repeat (2) @(posedge sys_clk_i);
    check(mhz, m);
    check(iomhz, {m, 1'b0});
    check(resv, m == 10'd0);
  endtask : freq_case

  // Program the count first, then let the threads send their pulses
  task sg_case(input logic [2:0] code, input logic [3:0] n, input logic sl, input logic [31:0] exp);
    int k;
    k = 0;
    ahb(1'b1, CFG_ADDR, {16'h0, code, 13'h0});
    ack_cnt = 0;
    pulses <= n;
    slow <= sl;
    start <= 1'b1;
    @(posedge sys_clk_i);
    start <= 1'b0;
    @(posedge sys_clk_i);
    while (idle !== 1'b1 && k < 40) begin
      @(posedge sys_clk_i);
      k++;
    end
    repeat (3) @(posedge sys_clk_i);
    check(ack_cnt, exp);
  endtask : sg_case

  // One reference; the decision stands in the cycle after it is taken
  task route_case(input hcr_rc_s c);
    vga <= c.vga;
    ahb(1'b1, CFG_ADDR, {26'h0, c.mda, 5'h0});
    mem_valid <= c.mem;
    io_valid <= !c.mem;
    mem_addr <= c.addr;
    io_addr <= c.addr[15:0];
    io_be <= c.be;
    @(posedge sys_clk_i);
    mem_valid <= 1'b0;
    io_valid <= 1'b0;
    @(posedge sys_clk_i);
    check({rvalid, rhub, rgfx, roth}, {1'b1, c.exp});
    check(illegal, !c.vga && c.mda);
  endtask : route_case

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #250000;
    err_total++;
    give_verdict;
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    check(mhz, 10'd0);
    check(resv, 1'b1);
    ahb(1'b0, CFG_ADDR, 32'h0);
    check(rdat, 32'h0);
    ahb(1'b1, CFG_ADDR, 32'hffffffff);
    ahb(1'b0, CFG_ADDR, 32'h0);
    check(rdat, 32'h0000ec20);
    ahb(1'b1, 32'h100, 32'h1);
    ahb(1'b0, 32'h100, 32'h0);
    check(rdat, 32'h0);
    for (int i = 0; i < 4; i++) freq_case(FB[i], FS[i]);
    sg_case(3'h0, 4'h3, 1'b0, 32'd3);
    sg_case(3'h1, 4'h4, 1'b1, 32'd2);
    sg_case(3'h1, 4'h6, 1'b0, 32'd3);
    sg_case(3'h2, 4'h2, 1'b0, 32'd2);
    for (int i = 0; i < 14; i++) route_case(RC[i]);
    give_verdict;
  end
endmodule : tb
